/* File: src/tsb_pkg.sv */
// Purpose: shared constants for the two-wire temperature sensor link
// Assumes: 40 MHz system clock on both ends
// Notes: timing counts derive from times and the clock rate
package tsb_pkg;
  localparam int CLK_HZ = 40000000; // system clock rate
  localparam logic [6:0] DEV_ADDR = 7'h4D; // own slave address 1001101
  localparam logic [7:0] CMD_TEMP = 8'h00; // temperature register pointer
  localparam logic [7:0] CMD_CONF = 8'h01; // configuration pointer
  localparam int CONF_STBY_BIT = 7; // standby request bit position
  localparam int CONF_RDY_BIT = 6; // conversion ready bit position
  localparam logic [7:0] CONF_RST = 8'h00; // configuration reset value
  localparam logic [7:0] TEMP_RST = 8'h00; // temperature reset value
  localparam int FIRST_CONV_MS = 250; // longest time to first result
  // longest time rounds down; a small conversion period keeps it inside
  localparam int FIRST_CONV_CYC = (CLK_HZ / 1000) * FIRST_CONV_MS;
  localparam int CONV_PERIOD_MS = 125; // nominal 8 samples per second
  localparam int CONV_PERIOD_CYC = (CLK_HZ / 1000) * CONV_PERIOD_MS;
  localparam int SCL_HALF_NS = 5000; // half period of a 100 kHz clock
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * 40) / 1000; // 25 ns clock
  localparam logic RD_DIR = 1'b1; // direction bit value for read
  localparam logic WR_DIR = 1'b0; // direction bit value for write
endpackage

/* File: src/tsb_if.sv */
// Purpose: open-drain two-wire link between host and sensor
// Assumes: pull-ups modelled by wired-and of the release enables
// Notes: an output enable low means that end pulls the wire low
`timescale 1ns/1ps
interface tsb_if;
  logic scl_oe_n_host; // host clock drive, low pulls line low
  logic sda_oe_n_host; // host data drive, low pulls line low
  logic sda_oe_n_dev; // device data drive, low pulls line low
  logic scl; // resolved clock line
  logic sda; // resolved data line
  assign scl = scl_oe_n_host;
  assign sda = sda_oe_n_host & sda_oe_n_dev;
  modport host (output scl_oe_n_host, output sda_oe_n_host,
    input scl, input sda);
  modport dev (output sda_oe_n_dev, input scl, input sda);
endinterface

/* File: src/tsb_dev.sv */
// Purpose: sensor end of the link, slave with temp and config registers
// Assumes: scl and sda come from pins and are synchronised here
// Notes: the converter is modelled by a sample input taken periodically
// Behaviour
// - device is slave, host clocks transfers
// - answer only to address 1001101
// - bytes move most significant bit first
// - falling data with clock high starts
// - rising data with clock high stops
// - data changes only while clock low
// - receiver pulls data low on ninth pulse
// - both lines high means idle bus
// - host frames each access start to stop
// - write byte: address, command, data, acks
// - read byte: repeated start, read, nack
// - receive byte uses last command pointer
// - standby bit one halts, zero runs
// - standby freezes temperature and conversions
// - serial port works during standby
// - temperature readable anytime without stall
// - first result ready within 250 ms
// - ack only own address, else release
// - eighth address bit: one read, zero write
// - temperature is two's complement degrees
`timescale 1ns/1ps
module tsb_dev #(
  parameter int CONV_CYC = tsb_pkg::CONV_PERIOD_CYC // conversion period
) (
  input wire logic clk,
  input wire logic reset,
  tsb_if.dev bus,
  input wire logic [7:0] sensor_sample, // converter result, degrees
  output logic [7:0] temp_out, // temperature register
  output logic [7:0] conf_out, // configuration register
  output logic standby, // standby mode active
  output logic busy // a transfer is in progress
);
  typedef enum {ST_IDLE, ST_BITS, ST_ACK, ST_SEND, ST_MACK, ST_IGNORE}
    tsb_dst_t; // transfer states
  tsb_dst_t st_reg, st_next;
  logic [1:0] scl_s_reg, scl_s_next; // clock synchroniser
  logic [1:0] sda_s_reg, sda_s_next; // data synchroniser
  logic scl_d_reg, scl_d_next; // delayed synced clock, for edges
  logic sda_d_reg, sda_d_next; // delayed synced data, for edges
  logic [7:0] sh_reg, sh_next; // shift register
  logic [3:0] cnt_reg, cnt_next; // bit counter
  logic [1:0] byte_reg, byte_next; // byte index in the write phase
  logic rd_reg, rd_next; // read direction latched
  logic [7:0] ptr_reg, ptr_next; // register pointer
  logic [7:0] temp_reg, temp_next; // temperature register
  logic stby_reg, stby_next; // standby request bit
  logic rdy_reg, rdy_next; // conversion ready bit
  logic oe_n_reg, oe_n_next; // data line release
  logic busy_reg, busy_next; // transfer active
  logic [31:0] tmr_reg, tmr_next; // conversion timer
  logic scl_rise, scl_fall, start_c, stop_c, scl_h, sda_h;
  logic [7:0] conf_v, rd_val;

  // only the second stage of each synchroniser is read
  assign scl_h = scl_s_reg[1];
  assign sda_h = sda_s_reg[1];
  assign scl_rise = scl_h & ~scl_d_reg;
  assign scl_fall = ~scl_h & scl_d_reg;
  assign start_c = scl_h & scl_d_reg & sda_d_reg & ~sda_h;
  assign stop_c = scl_h & scl_d_reg & ~sda_d_reg & sda_h;
  assign conf_v = {stby_reg, rdy_reg, 6'h00};
  // pointer picks the register; unknown pointers read zero
  assign rd_val = (ptr_reg == tsb_pkg::CMD_TEMP) ? temp_reg :
    (ptr_reg == tsb_pkg::CMD_CONF) ? conf_v : 8'h00;

  // conversion engine: timer, sampling and ready flag
  always_comb begin
    temp_next = temp_reg;
    rdy_next = rdy_reg;
    tmr_next = tmr_reg;
    if (stby_reg) begin
      // halt and freeze; ready clears on standby entry
      tmr_next = 32'h0;
      rdy_next = 1'b0;
    end else if (tmr_reg >= CONV_CYC - 1) begin
      tmr_next = 32'h0;
      temp_next = sensor_sample;
      rdy_next = 1'b1;
    end else begin
      tmr_next = tmr_reg + 32'h1;
    end
  end

  // serial engine: sync, edge find, framing, shifting
  always_comb begin
    scl_s_next = {scl_s_reg[0], bus.scl};
    sda_s_next = {sda_s_reg[0], bus.sda};
    scl_d_next = scl_h;
    sda_d_next = sda_h;
    st_next = st_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    byte_next = byte_reg;
    rd_next = rd_reg;
    ptr_next = ptr_reg;
    stby_next = stby_reg;
    oe_n_next = oe_n_reg;
    busy_next = busy_reg;
    if (start_c) begin
      // start or repeated start always resynchronises the slave
      st_next = ST_BITS;
      cnt_next = 4'h0;
      byte_next = 2'h0;
      oe_n_next = 1'b1;
      busy_next = 1'b1;
    end else if (stop_c) begin
      // pointer survives the stop
      st_next = ST_IDLE;
      oe_n_next = 1'b1;
      busy_next = 1'b0;
    end else begin
      case (st_reg)
        ST_BITS: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_h};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            cnt_next = 4'h0;
            if (byte_reg == 2'h0) begin
              if (sh_reg[7:1] == tsb_pkg::DEV_ADDR) begin
                rd_next = (sh_reg[0] == tsb_pkg::RD_DIR);
                oe_n_next = 1'b0;
                st_next = ST_ACK;
              end else begin
                st_next = ST_IGNORE;
              end
            end else begin
              if (byte_reg == 2'h1) begin
                ptr_next = sh_reg;
              end else if (ptr_reg == tsb_pkg::CMD_CONF) begin
                stby_next = sh_reg[tsb_pkg::CONF_STBY_BIT];
              end
              oe_n_next = 1'b0;
              st_next = ST_ACK;
            end
          end
        end
        ST_ACK: begin
          // leave the ack slot after the ninth pulse, in the low phase
          if (scl_fall) begin
            if (byte_reg != 2'h3) begin
              byte_next = byte_reg + 2'h1;
            end
            // in a read every ack slot is followed by the selected byte
            if (rd_reg) begin
              oe_n_next = rd_val[7];
              sh_next = {rd_val[6:0], 1'b0};
              cnt_next = 4'h1;
              st_next = ST_SEND;
            end else begin
              oe_n_next = 1'b1;
              st_next = ST_BITS;
            end
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            if (cnt_reg == 4'h8) begin
              oe_n_next = 1'b1;
              st_next = ST_MACK;
            end else begin
              oe_n_next = sh_reg[7];
              sh_next = {sh_reg[6:0], 1'b0};
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        ST_MACK: begin
          // host nack ends the read; an ack sends the byte again
          if (scl_rise) begin
            st_next = sda_h ? ST_IGNORE : ST_ACK;
          end
        end
        ST_IGNORE: oe_n_next = 1'b1;
        ST_IDLE: oe_n_next = 1'b1;
        default: st_next = ST_IDLE;
      endcase
    end
  end

  // register all state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= ST_IDLE;
      scl_s_reg <= 2'h3;
      sda_s_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      byte_reg <= 2'h0;
      rd_reg <= 1'b0;
      ptr_reg <= tsb_pkg::CMD_TEMP;
      temp_reg <= tsb_pkg::TEMP_RST;
      stby_reg <= tsb_pkg::CONF_RST[tsb_pkg::CONF_STBY_BIT];
      rdy_reg <= tsb_pkg::CONF_RST[tsb_pkg::CONF_RDY_BIT];
      oe_n_reg <= 1'b1;
      busy_reg <= 1'b0;
      tmr_reg <= 32'h0;
    end else begin
      st_reg <= st_next;
      scl_s_reg <= scl_s_next;
      sda_s_reg <= sda_s_next;
      scl_d_reg <= scl_d_next;
      sda_d_reg <= sda_d_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      byte_reg <= byte_next;
      rd_reg <= rd_next;
      ptr_reg <= ptr_next;
      temp_reg <= temp_next;
      stby_reg <= stby_next;
      rdy_reg <= rdy_next;
      oe_n_reg <= oe_n_next;
      busy_reg <= busy_next;
      tmr_reg <= tmr_next;
    end
  end

  assign bus.sda_oe_n_dev = oe_n_reg;
  assign temp_out = temp_reg;
  assign conf_out = conf_v;
  assign standby = stby_reg;
  assign busy = busy_reg;
endmodule

/* File: src/tsb_host.sv */
// Purpose: host master end, runs write, read and receive byte accesses
// Assumes: device answers within the clock low phase
// Notes: clock is divided from clk; data moves mid low phase
`timescale 1ns/1ps
module tsb_host #(
  parameter int HALF_CYC = tsb_pkg::SCL_HALF_CYC // half clock period
) (
  input wire logic clk,
  input wire logic reset,
  tsb_if.host bus,
  input wire logic go, // pulse: start an access
  input wire logic [1:0] op, // 0 write, 1 read, 2 receive byte
  input wire logic [7:0] cmd, // command byte
  input wire logic [7:0] wdata, // data for write byte
  output logic ready, // idle, go accepted
  output logic done, // pulse: access finished
  output logic nak, // an acknowledge was missing
  output logic [7:0] rdata // byte read
);
  typedef enum {H_IDLE, H_START, H_BIT, H_STOP} tsb_hst_t;
  tsb_hst_t st_reg, st_next;
  logic [15:0] div_reg, div_next; // quarter phase divider
  logic [1:0] ph_reg, ph_next; // quarter: 0 to 2 low, 3 high
  logic [7:0] sh_reg, sh_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [2:0] byte_reg, byte_next; // byte index in the access
  logic [1:0] op_reg, op_next;
  logic [7:0] cmd_reg, cmd_next, wd_reg, wd_next, rd_reg, rd_next;
  logic scl_reg, scl_next, sda_reg, sda_next;
  logic nak_reg, nak_next, done_reg, done_next;
  logic [1:0] sda_s_reg, sda_s_next; // data line synchroniser
  logic tick, rx_byte;
  logic [2:0] last_b;

  assign tick = (div_reg == 16'(HALF_CYC / 2 - 1));
  // receive phase: the data byte of read or receive accesses
  assign rx_byte = (op_reg == 2'h1 && byte_reg == 3'h3) ||
    (op_reg == 2'h2 && byte_reg == 3'h1);
  assign last_b = (op_reg == 2'h2) ? 3'h1 : (op_reg == 2'h1) ? 3'h3 : 3'h2;

  // byte loader: address, command, data in the access order
  function automatic logic [7:0] load(input logic [2:0] b,
    input logic [1:0] o, input logic [7:0] c, input logic [7:0] w);
    logic [7:0] v;
    v = {tsb_pkg::DEV_ADDR, tsb_pkg::WR_DIR};
    if (b == 3'h0 && o == 2'h2) v = {tsb_pkg::DEV_ADDR, tsb_pkg::RD_DIR};
    if (b == 3'h1 && o != 2'h2) v = c;
    if (b == 3'h2 && o == 2'h0) v = w;
    if (b == 3'h2 && o == 2'h1) v = {tsb_pkg::DEV_ADDR, tsb_pkg::RD_DIR};
    return v;
  endfunction

  // sequencer: one step per quarter clock
  always_comb begin
    div_next = tick ? 16'h0 : div_reg + 16'h1;
    sda_s_next = {sda_s_reg[0], bus.sda};
    st_next = st_reg;
    ph_next = ph_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    byte_next = byte_reg;
    op_next = op_reg;
    cmd_next = cmd_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    scl_next = scl_reg;
    sda_next = sda_reg;
    nak_next = nak_reg;
    done_next = 1'b0;
    case (st_reg)
      H_IDLE: begin
        scl_next = 1'b1;
        sda_next = 1'b1;
        if (go) begin
          op_next = op;
          cmd_next = cmd;
          wd_next = wdata;
          nak_next = 1'b0;
          byte_next = 3'h0;
          ph_next = 2'h0;
          st_next = H_START;
        end
      end
      H_START: if (tick) begin
        // data falls while clock high, then clock goes low
        ph_next = ph_reg + 2'h1;
        if (ph_reg == 2'h0) sda_next = 1'b1;
        if (ph_reg == 2'h1) scl_next = 1'b1;
        if (ph_reg == 2'h2) sda_next = 1'b0;
        if (ph_reg == 2'h3) begin
          scl_next = 1'b0;
          sh_next = load(byte_reg, op_reg, cmd_reg, wd_reg);
          cnt_next = 4'h0;
          st_next = H_BIT;
        end
      end
      H_BIT: if (tick) begin
        ph_next = ph_reg + 2'h1;
        if (ph_reg == 2'h1) begin
          // set data in the low phase; release on ack or receive
          // ninth bit: release for the device ack, or nack a read byte
          if (cnt_reg == 4'h8) sda_next = 1'b1;
          else sda_next = rx_byte ? 1'b1 : sh_reg[7];
        end
        if (ph_reg == 2'h2) scl_next = 1'b1;
        if (ph_reg == 2'h3) begin
          scl_next = 1'b0;
          if (cnt_reg == 4'h8) begin
            if (!rx_byte && sda_s_reg[1]) nak_next = 1'b1;
            cnt_next = 4'h0;
            byte_next = byte_reg + 3'h1;
            sh_next = load(byte_reg + 3'h1, op_reg, cmd_reg, wd_reg);
            if (byte_reg == last_b || (!rx_byte && sda_s_reg[1]))
              st_next = H_STOP;
            else if (op_reg == 2'h1 && byte_reg == 3'h1) begin
              ph_next = 2'h0;
              st_next = H_START;
            end
          end else begin
            if (rx_byte) rd_next = {rd_reg[6:0], sda_s_reg[1]};
            sh_next = {sh_reg[6:0], 1'b0};
            cnt_next = cnt_reg + 4'h1;
          end
        end
      end
      H_STOP: if (tick) begin
        // data rises while clock high
        ph_next = ph_reg + 2'h1;
        if (ph_reg == 2'h1) sda_next = 1'b0;
        if (ph_reg == 2'h2) scl_next = 1'b1;
        if (ph_reg == 2'h3) begin
          sda_next = 1'b1;
          done_next = 1'b1;
          st_next = H_IDLE;
        end
      end
      default: st_next = H_IDLE;
    endcase
  end

  // register all state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= H_IDLE;
      div_reg <= 16'h0;
      ph_reg <= 2'h0;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      byte_reg <= 3'h0;
      op_reg <= 2'h0;
      cmd_reg <= 8'h00;
      wd_reg <= 8'h00;
      rd_reg <= 8'h00;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      nak_reg <= 1'b0;
      done_reg <= 1'b0;
      sda_s_reg <= 2'h3;
    end else begin
      st_reg <= st_next;
      div_reg <= div_next;
      ph_reg <= ph_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      byte_reg <= byte_next;
      op_reg <= op_next;
      cmd_reg <= cmd_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      nak_reg <= nak_next;
      done_reg <= done_next;
      sda_s_reg <= sda_s_next;
    end
  end

  assign bus.scl_oe_n_host = scl_reg;
  assign bus.sda_oe_n_host = sda_reg;
  assign ready = (st_reg == H_IDLE);
  assign done = done_reg;
  assign nak = nak_reg;
  assign rdata = rd_reg;
endmodule

/* File: sim/tsb_properties.sv */
// Purpose: wire checks of the link between host and sensor
// Assumes: one clock domain, reset active high
// Notes: helper logic counts clock pulses to find the ack slots
`timescale 1ns/1ps
module tsb_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_oe_n_host,
  input wire logic sda_oe_n_host,
  input wire logic sda_oe_n_dev,
  input wire logic scl,
  input wire logic sda
);
  localparam int LOW_MAX = 40; // host half period is 16 clocks
  logic scl_q_reg, scl_q_next; // lines one clock ago
  logic sda_q_reg, sda_q_next;
  logic [3:0] cnt_reg, cnt_next; // clock pulses in this byte
  logic [7:0] sh_reg, sh_next; // byte bits, msb first
  logic fb_reg, fb_next; // address byte in flight
  logic dir_reg, dir_next; // direction of last address
  logic start_ev, stop_ev, rise_ev, ack9; // decoded events

  // byte tracker; a repeated start restarts the address phase
  always_comb begin
    start_ev = scl & scl_q_reg & sda_q_reg & ~sda;
    stop_ev = scl & scl_q_reg & ~sda_q_reg & sda;
    rise_ev = scl & ~scl_q_reg;
    ack9 = rise_ev & (cnt_reg == 4'h8);
    scl_q_next = scl;
    sda_q_next = sda;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    fb_next = fb_reg;
    dir_next = dir_reg;
    if (start_ev) begin
      cnt_next = 4'h0;
      fb_next = 1'b1;
    end else if (rise_ev) begin
      cnt_next = ack9 ? 4'h0 : cnt_reg + 4'h1;
      if (cnt_reg < 4'h8) begin
        sh_next = {sh_reg[6:0], sda};
      end
      if (ack9 && fb_reg) begin // address over, keep direction
        fb_next = 1'b0;
        dir_next = sh_reg[0];
      end
    end
  end

  // registers only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      fb_reg <= 1'b0;
      dir_reg <= 1'b0;
    end else begin
      scl_q_reg <= scl_q_next;
      sda_q_reg <= sda_q_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      fb_reg <= fb_next;
      dir_reg <= dir_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_high_hold;
    scl [*5];
  endsequence
  sequence s_dev_quiet;
    sda_oe_n_dev [*8];
  endsequence

  AST_RESET_IDLE: assert property (
    $fell(reset) |-> scl && sda && sda_oe_n_dev)
    else $error("lines not idle after reset");
  AST_SCL_HIGH_MIN: assert property (
    $rose(scl) |=> s_high_hold)
    else $error("clock high phase too short");
  AST_SCL_LOW_MAX: assert property (
    $fell(scl) |-> ##[1:LOW_MAX] scl)
    else $error("clock stuck low");
  AST_DEV_STABLE: assert property (
    scl && scl_q_reg |-> $stable(sda_oe_n_dev))
    else $error("device moved data while clock high");
  AST_HOST_STABLE: assert property (
    scl_oe_n_host && scl_q_reg && $changed(sda_oe_n_host)
      |-> start_ev || stop_ev)
    else $error("host moved data while clock high");
  AST_ADDR_ACK: assert property (
    ack9 && fb_reg && sh_reg[7:1] == tsb_pkg::DEV_ADDR |-> !sda_oe_n_dev)
    else $error("own address not acknowledged");
  AST_ADDR_SILENT: assert property (
    fb_reg && cnt_reg < 4'h8 |-> sda_oe_n_dev)
    else $error("device drove data during address");
  AST_WR_ACK: assert property (
    ack9 && !fb_reg && !dir_reg |-> !sda_oe_n_dev)
    else $error("written byte not acknowledged");
  AST_READ_NACK: assert property (
    ack9 && !fb_reg && dir_reg |-> sda && sda_oe_n_dev)
    else $error("read byte not ended by nack");
  AST_STOP_QUIET: assert property (
    stop_ev |-> s_dev_quiet)
    else $error("device drove data after stop");
endmodule

/* File: sim/smbus_temp_sensor_slave_tb_top.sv */
// Purpose: random and corner tests of host and sensor ends
// Assumes: 40 MHz clock, inputs change on falling edge
// Notes: a second link is hand driven with foreign and own addresses
`timescale 1ns/1ps
module smbus_temp_sensor_slave_tb_top;
  localparam int CONV = 5000; // short conversion period, run length
  localparam int Q = 8; // quarter bit of the hand-driven link
  logic clk, reset, go, ready, done, nak, stby, stby2, a, busy, sb;
  logic [1:0] op;
  logic [7:0] cmd, wdata, rdata, sample, temp, conf, old, mon_sh, mon_addr;
  int n_errors, checks, mon_n, i;
  tsb_if bus();
  tsb_if bus2(); // fault link, host side driven here
  tsb_host #(.HALF_CYC(16)) tsb_host_inst (.clk(clk), .reset(reset),
    .bus(bus), .go(go), .op(op), .cmd(cmd), .wdata(wdata),
    .ready(ready), .done(done), .nak(nak), .rdata(rdata));
  tsb_dev #(.CONV_CYC(CONV)) tsb_dev_inst (.clk(clk), .reset(reset),
    .bus(bus), .sensor_sample(sample), .temp_out(temp),
    .conf_out(conf), .standby(stby), .busy(busy));
  tsb_dev #(.CONV_CYC(CONV)) tsb_dev_inst_b (.clk(clk), .reset(reset),
    .bus(bus2), .sensor_sample(sample), .temp_out(), .conf_out(),
    .standby(stby2), .busy());
  tsb_properties tsb_properties_inst (.clk(clk), .reset(reset),
    .scl_oe_n_host(bus.scl_oe_n_host), .sda_oe_n_host(bus.sda_oe_n_host),
    .sda_oe_n_dev(bus.sda_oe_n_dev), .scl(bus.scl), .sda(bus.sda));

  // clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // wire monitor: keeps the last address byte seen after a start
  always @(negedge bus.sda) if (bus.scl === 1'b1) mon_n = 0;
  always @(posedge bus.scl) begin
    mon_sh = {mon_sh[6:0], bus.sda};
    mon_n = mon_n + 1;
    if (mon_n == 8) mon_addr = mon_sh;
  end

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // configuration byte as it should read, reserved bits zero
  function automatic logic [7:0] exp_conf(input logic s, input logic r);
    logic [7:0] v;
    v = 8'h00;
    v[tsb_pkg::CONF_STBY_BIT] = s;
    v[tsb_pkg::CONF_RDY_BIT] = r;
    return v;
  endfunction

  // one host access; waits are bounded so a hang still ends
  task automatic access(input logic [1:0] o, input logic [7:0] c,
                        input logic [7:0] w);
    for (i = 0; i < 100 && ready !== 1'b1; i++) @(negedge clk);
    go = 1'b1;
    op = o;
    cmd = c;
    wdata = w;
    @(negedge clk);
    go = 1'b0;
    sb = 1'b0;
    for (i = 0; i < 3000 && done !== 1'b1; i++) begin
      @(negedge clk);
      sb = sb | busy;
    end
    chk("done", {7'h00, done}, 8'h01);
    chk("nak", {7'h00, nak}, 8'h00);
    chk("addr", mon_addr, {tsb_pkg::DEV_ADDR, o != 2'h0});
    chk("busy seen", {7'h00, sb}, 8'h01);
    // the device sees the stop a few clocks after done, through its flops
    repeat (4) @(negedge clk);
    chk("busy end", {7'h00, busy}, 8'h00);
  endtask

  task automatic qwait;
    repeat (Q) @(negedge clk);
  endtask
  task automatic bb_start; // sda high first so it also repeats a start
    bus2.sda_oe_n_host = 1'b1;
    qwait();
    bus2.scl_oe_n_host = 1'b1;
    qwait();
    bus2.sda_oe_n_host = 1'b0;
    qwait();
    bus2.scl_oe_n_host = 1'b0;
    qwait();
  endtask
  task automatic bb_stop;
    bus2.sda_oe_n_host = 1'b0;
    qwait();
    bus2.scl_oe_n_host = 1'b1;
    qwait();
    bus2.sda_oe_n_host = 1'b1;
    qwait();
  endtask
  // sends a byte msb first, then a released ninth bit for the ack
  task automatic bb_byte(input logic [7:0] v, output logic ack);
    logic [8:0] s;
    s = {v, 1'b1};
    for (int k = 8; k >= 0; k--) begin
      bus2.sda_oe_n_host = s[k];
      qwait();
      bus2.scl_oe_n_host = 1'b1;
      qwait();
      ack = ~bus2.sda;
      qwait();
      bus2.scl_oe_n_host = 1'b0;
      qwait();
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog: about twice the expected run
  initial begin
    repeat (80000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h028EF3F0));
    {n_errors, checks, mon_n} = '0;
    {go, op, cmd, wdata} = '0;
    reset = 1'b1;
    sample = 8'($urandom);
    bus2.scl_oe_n_host = 1'b1;
    bus2.sda_oe_n_host = 1'b1;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    chk("temp rst", temp, tsb_pkg::TEMP_RST);
    chk("conf rst", conf, tsb_pkg::CONF_RST);
    for (i = 0; i < CONV + 50 && conf[6] !== 1'b1; i++) @(negedge clk);
    chk("first ready", conf, exp_conf(1'b0, 1'b1));
    chk("first temp", temp, sample);
    $display("test first_result done");
    access(2'h1, tsb_pkg::CMD_TEMP, 8'h00);
    chk("read temp", rdata, sample);
    access(2'h2, 8'h00, 8'h00);
    chk("receive temp", rdata, sample);
    access(2'h1, tsb_pkg::CMD_CONF, 8'h00);
    access(2'h2, 8'h00, 8'h00);
    chk("receive conf", rdata, exp_conf(1'b0, 1'b1));
    $display("test pointer done");
    access(2'h0, tsb_pkg::CMD_CONF, {1'b1, 7'($urandom)});
    chk("standby", {7'h00, stby}, 8'h01);
    chk("conf standby", conf, exp_conf(1'b1, 1'b0));
    old = sample;
    sample = ~old;
    repeat (CONV + 200) @(negedge clk);
    chk("frozen temp", temp, old);
    access(2'h1, tsb_pkg::CMD_TEMP, 8'h00);
    chk("standby read", rdata, old);
    access(2'h0, tsb_pkg::CMD_CONF, 8'h00);
    chk("normal", {7'h00, stby}, 8'h00);
    repeat (CONV + 100) @(negedge clk);
    chk("new temp", temp, sample);
    $display("test standby done");
    repeat (4) begin
      cmd = 8'h02 + 8'($urandom % 254);
      access(2'h0, cmd, 8'($urandom));
      access(2'h1, cmd, 8'h00);
      chk("unknown ptr", rdata, 8'h00);
      access(2'h0, tsb_pkg::CMD_CONF, {1'b0, 7'($urandom)});
      access(2'h1, tsb_pkg::CMD_CONF, 8'h00);
      chk("conf back", rdata, exp_conf(1'b0, 1'b1));
    end
    $display("test random done");
    old = 8'($urandom);
    if (old[7:1] == tsb_pkg::DEV_ADDR) old = old ^ 8'h02;
    bb_start();
    bb_byte({old[7:1], tsb_pkg::WR_DIR}, a);
    chk("foreign ack", {7'h00, a}, 8'h00);
    bb_byte(tsb_pkg::CMD_CONF, a);
    bb_byte(8'h80, a);
    chk("ignored ack", {7'h00, a}, 8'h00);
    bb_stop();
    chk("ignored write", {7'h00, stby2}, 8'h00);
    bb_start();
    bb_byte({tsb_pkg::DEV_ADDR, tsb_pkg::WR_DIR}, a);
    chk("own ack", {7'h00, a}, 8'h01);
    bb_byte(tsb_pkg::CMD_CONF, a);
    bb_byte(8'h80, a);
    chk("data ack", {7'h00, a}, 8'h01);
    bb_stop();
    qwait();
    chk("hand write", {7'h00, stby2}, 8'h01);
    $display("test fault_link done");
    report_and_stop();
  end
endmodule
